// ---- rtl/pwm_fine_step_pkg.sv ----
// constants shared by the fine step pulse width generator and its channels
// assumes one 250 MHz clock and a 32-bit AXI4-Lite register port
`default_nettype none
package pwm_fine_step_pkg;
    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_CH = 2;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_PULSE_WEIGHT_CH2 = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_PULSE_WEIGHT_CH3 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RATE_MULT_CH3_CH2 = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CHANNEL_ENABLE = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;

    // pulse weight register fields
    localparam int PW_WEIGHT_LSB = 0;
    localparam int PW_WEIGHT_W = 6;
    localparam int PW_POL_BIT = 6;
    localparam int PW_RSVD_BIT = 7;
    localparam logic PW_RSVD_VALUE = 1'b1;
    localparam int RATE_W = 4;

    // reset values of the software registers
    localparam logic [6:0] PW_RESET = 7'h00;
    localparam logic [7:0] RATE_RESET = 8'h00;
    localparam logic [1:0] ENABLE_RESET = 2'h0;

    // status register fields
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_INDEX_LSB = 6;
    localparam int STAT_EFF_CH2_LSB = 10;
    localparam int STAT_EFF_CH3_LSB = 20;

    // modulator counter
    localparam int CNT_W = 6;
    localparam int IDX_W = 4;
    localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
    localparam logic [CNT_W-1:0] CNT_LOAD = 6'h3e;
    localparam logic [CNT_W-1:0] CNT_STEP = 6'h01;
    localparam logic [IDX_W-1:0] IDX_STEP = 4'h1;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // periods of the 16-period sequence that get the extra clock
    function automatic logic rate_select(input logic [IDX_W-1:0] idx,
                                         input logic [RATE_W-1:0] rate);
        logic hit;
        hit = 1'b0;
        if (rate[0] && idx == 4'h8)
            hit = 1'b1;
        if (rate[1] && idx[2:0] == 3'h4)
            hit = 1'b1;
        if (rate[2] && idx[1:0] == 2'h2)
            hit = 1'b1;
        if (rate[3] && idx[0])
            hit = 1'b1;
        return hit;
    endfunction
endpackage
`default_nettype wire

// ---- rtl/pwm_fine_step_channel.sv ----
// one output channel: shadowed weight, polarity, enable and widening decision
// assumes count_nxt, load and idx_next come from the shared modulator counter
`default_nettype none
module pwm_fine_step_channel
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // shared time base
    input wire logic [pwm_fine_step_pkg::CNT_W-1:0] count_nxt,
    input wire logic load,
    input wire logic [pwm_fine_step_pkg::IDX_W-1:0] idx_next,
    // live software settings
    input wire logic [6:0] weight_pol,
    input wire logic [pwm_fine_step_pkg::RATE_W-1:0] rate,
    input wire logic enable,
    // pin
    output logic chan_out
);
    import pwm_fine_step_pkg::*;

    typedef struct packed {
        logic [PW_WEIGHT_W-1:0] weight;
        logic output_polarity;
        logic en;
        logic widen;
        logic out;
    } chan_s;

    chan_s cur_r;
    chan_s cur_nxt;
    logic active;

    // settings are sampled one clock before the lead-in slot so a period never
    // mixes old and new values
    always_comb
    begin
        cur_nxt = cur_r;
        if (load)
        begin
            cur_nxt.weight = weight_pol[PW_WEIGHT_LSB +: PW_WEIGHT_W];
            cur_nxt.output_polarity = weight_pol[PW_POL_BIT];
            cur_nxt.en = enable;
            cur_nxt.widen = rate_select(idx_next, rate);
        end
        // the extra clock sits in the slot just before the period starts
        if (count_nxt == CNT_MAX)
            active = cur_nxt.widen;
        else
            active = count_nxt < cur_nxt.weight;
        cur_nxt.out = (active && cur_nxt.en) ^ cur_nxt.output_polarity;
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cur_r <= '0;
        else
            cur_r <= cur_nxt;
    end

    assign chan_out = cur_r.out;
endmodule
`default_nettype wire

// ---- rtl/pwm_fine_step_generator.sv ----
// fine step pulse width generator: 6-bit modulator plus 4-bit rate multiplier
// for two channels, with an AXI4-Lite register slave
// assumes one clock, synchronous active-low reset, and an rc filter on each pin
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`default_nettype none
module pwm_fine_step_generator
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi write address channel
    input wire logic [pwm_fine_step_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi write data channel
    input wire logic [pwm_fine_step_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi read address channel
    input wire logic [pwm_fine_step_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi read data channel
    output logic [pwm_fine_step_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // outputs to the external filters
    output logic pwm_out_ch2,
    output logic pwm_out_ch3
);
    import pwm_fine_step_pkg::*;

    typedef enum logic {wr_accept, wr_resp} write_e;
    typedef enum logic {rd_accept, rd_data} read_e;

    typedef struct packed {
        // write side of the slave
        write_e wr;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] waddr;
        logic [7:0] wbyte;
        logic wlane;
        // read side of the slave
        read_e rd;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        // modulator time base
        logic [CNT_W-1:0] count;
        logic [IDX_W-1:0] idx;
        // software registers, polarity above six weight bits
        logic [NUM_CH-1:0][6:0] pw;
        logic [7:0] rate;
        logic [NUM_CH-1:0] en;
    } state_s;

    state_s cur_r;
    state_s cur_nxt;

    logic aw_fire;
    logic w_fire;
    logic have_aw;
    logic have_w;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane;
    logic [ADDR_W-1:0] rd_word;
    logic [ADDR_W-1:0] wr_word;
    logic [DATA_W-1:0] rd_value;
    logic rd_hit;
    logic wr_hit;
    logic [NUM_CH-1:0][9:0] eff_value;
    logic [CNT_W-1:0] count_nxt;
    logic load;
    logic [IDX_W-1:0] idx_next;
    logic [NUM_CH-1:0] chan_pins;

    // combined 10-bit value {weight, rate nibble} per channel, without enable or polarity applied
    always_comb
    begin
        for (int c = 0; c < NUM_CH; c++)
            eff_value[c] = {cur_r.pw[c][PW_WEIGHT_W-1:0], cur_r.rate[RATE_W*c +: RATE_W]};
    end

    // time base taps handed to the channels; load fires one clock ahead of the
    // lead-in slot so the widening decision is ready when the slot begins
    assign count_nxt = cur_r.count + CNT_STEP;
    assign load = cur_r.count == CNT_LOAD;
    assign idx_next = cur_r.idx + IDX_STEP;

    // word-aligned addresses, byte offset bits ignored
    assign rd_word = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    assign wr_word = {wr_addr[ADDR_W-1:2], 2'b00};

    // read decode; unmapped words return zero with an error response
    always_comb
    begin
        rd_value = '0;
        rd_hit = 1'b1;
        unique case (rd_word)
            OFF_PULSE_WEIGHT_CH2:
                rd_value[7:0] = {PW_RSVD_VALUE, cur_r.pw[0]};
            OFF_PULSE_WEIGHT_CH3:
                rd_value[7:0] = {PW_RSVD_VALUE, cur_r.pw[1]};
            OFF_RATE_MULT_CH3_CH2:
                rd_value[7:0] = cur_r.rate;
            OFF_CHANNEL_ENABLE:
                rd_value[NUM_CH-1:0] = cur_r.en;
            OFF_STATUS:
            begin
                rd_value[STAT_COUNT_LSB +: CNT_W] = cur_r.count;
                rd_value[STAT_INDEX_LSB +: IDX_W] = cur_r.idx;
                rd_value[STAT_EFF_CH2_LSB +: 10] = eff_value[0];
                rd_value[STAT_EFF_CH3_LSB +: 10] = eff_value[1];
            end
            default:
                rd_hit = 1'b0;
        endcase
    end

    // write decode; the status word is read only and silently ignores writes
    always_comb
    begin
        unique case (wr_word)
            OFF_PULSE_WEIGHT_CH2,
            OFF_PULSE_WEIGHT_CH3,
            OFF_RATE_MULT_CH3_CH2,
            OFF_CHANNEL_ENABLE,
            OFF_STATUS:
                wr_hit = 1'b1;
            default:
                wr_hit = 1'b0;
        endcase
    end

    // address and data may arrive in either order or together; the fresh
    // handshake is used directly so a paired write costs no extra clock
    assign aw_fire = s_axi_awvalid && cur_r.awready;
    assign w_fire = s_axi_wvalid && cur_r.wready;
    assign have_aw = cur_r.aw_got || aw_fire;
    assign have_w = cur_r.w_got || w_fire;
    assign wr_addr = cur_r.aw_got ? cur_r.waddr : s_axi_awaddr;
    assign wr_byte = cur_r.w_got ? cur_r.wbyte : s_axi_wdata[7:0];
    assign wr_lane = cur_r.w_got ? cur_r.wlane : s_axi_wstrb[0];

    // next state of the whole block
    always_comb
    begin
        cur_nxt = cur_r;

        // free-running counter; the six-bit width gives the wrap at 64
        cur_nxt.count = count_nxt;
        if (cur_r.count == CNT_MAX)
            cur_nxt.idx = idx_next;

        // capture whichever write half arrives first
        if (aw_fire)
        begin
            cur_nxt.aw_got = 1'b1;
            cur_nxt.waddr = s_axi_awaddr;
            cur_nxt.awready = 1'b0;
        end
        if (w_fire)
        begin
            cur_nxt.w_got = 1'b1;
            cur_nxt.wbyte = s_axi_wdata[7:0];
            cur_nxt.wlane = s_axi_wstrb[0];
            cur_nxt.wready = 1'b0;
        end

        // write sequencing
        unique case (cur_r.wr)
            wr_accept:
            begin
                if (have_aw && have_w)
                begin
                    // registers are eight bits wide, so only lane 0 matters
                    if (wr_lane)
                    begin
                        if (wr_word == OFF_PULSE_WEIGHT_CH2)
                            cur_nxt.pw[0] = wr_byte[6:0];
                        if (wr_word == OFF_PULSE_WEIGHT_CH3)
                            cur_nxt.pw[1] = wr_byte[6:0];
                        if (wr_word == OFF_RATE_MULT_CH3_CH2)
                            cur_nxt.rate = wr_byte;
                        if (wr_word == OFF_CHANNEL_ENABLE)
                            cur_nxt.en = wr_byte[NUM_CH-1:0];
                    end
                    cur_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
                    cur_nxt.bvalid = 1'b1;
                    cur_nxt.aw_got = 1'b0;
                    cur_nxt.w_got = 1'b0;
                    cur_nxt.awready = 1'b0;
                    cur_nxt.wready = 1'b0;
                    cur_nxt.wr = wr_resp;
                end
            end
            wr_resp:
            begin
                // both readies stay low until the response is taken, which
                // keeps a single write in flight
                if (s_axi_bready)
                begin
                    cur_nxt.bvalid = 1'b0;
                    cur_nxt.awready = 1'b1;
                    cur_nxt.wready = 1'b1;
                    cur_nxt.wr = wr_accept;
                end
            end
        endcase

        // read sequencing
        unique case (cur_r.rd)
            rd_accept:
            begin
                if (s_axi_arvalid && cur_r.arready)
                begin
                    cur_nxt.rdata = rd_value;
                    cur_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
                    cur_nxt.rvalid = 1'b1;
                    cur_nxt.arready = 1'b0;
                    cur_nxt.rd = rd_data;
                end
            end
            rd_data:
            begin
                if (s_axi_rready)
                begin
                    cur_nxt.rvalid = 1'b0;
                    cur_nxt.arready = 1'b1;
                    cur_nxt.rd = rd_accept;
                end
            end
        endcase
    end

    // state register; readies come up high so the first request is taken at once
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cur_r <= '0;
            cur_r.awready <= 1'b1;
            cur_r.wready <= 1'b1;
            cur_r.arready <= 1'b1;
            cur_r.pw <= {PW_RESET, PW_RESET};
            cur_r.rate <= RATE_RESET;
            cur_r.en <= ENABLE_RESET;
        end
        else
        begin
            cur_r <= cur_nxt;
        end
    end

    // one channel per weight register; the rate register is split by nibble
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_chan
        pwm_fine_step_channel u_chan
        (
            .aclk(aclk),
            .aresetn(aresetn),
            .count_nxt(count_nxt),
            .load(load),
            .idx_next(idx_next),
            .weight_pol(cur_r.pw[g]),
            .rate(cur_r.rate[RATE_W*g +: RATE_W]),
            .enable(cur_r.en[g]),
            .chan_out(chan_pins[g])
        );
    end

    // pin and bus outputs, each the q of a flip-flop
    assign pwm_out_ch2 = chan_pins[0];
    assign pwm_out_ch3 = chan_pins[1];
    assign s_axi_awready = cur_r.awready;
    assign s_axi_wready = cur_r.wready;
    assign s_axi_bvalid = cur_r.bvalid;
    assign s_axi_bresp = cur_r.bresp;
    assign s_axi_arready = cur_r.arready;
    assign s_axi_rvalid = cur_r.rvalid;
    assign s_axi_rdata = cur_r.rdata;
    assign s_axi_rresp = cur_r.rresp;
endmodule
`default_nettype wire

// ---- verification/pwm_rc_filter.sv ----
// behavioural stand-in for the rc filter on one pin
// assumes the bench clears it at the start of each measuring window
`default_nettype none
module pwm_rc_filter
(
    // clock and control
    input wire logic aclk,
    input wire logic clr,
    // pin and stored charge
    input wire logic pin,
    output logic [10:0] charge
);
    // ideal integrator: over a full sequence the charge is the duty value
    always_ff @(posedge aclk)
    begin
        if (clr)
            charge <= 11'h000;
        else
            charge <= charge + {10'h000, pin};
    end
endmodule
`default_nettype wire

// ---- verification/pwm_fine_step_monitor.sv ----
// checker on the generator ports: bus answers, readback and pin shape
// assumes one clock and a synchronous active-low reset
`default_nettype none
module pwm_fine_step_monitor
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins
    input wire logic pwm_out_ch2,
    input wire logic pwm_out_ch3
);
    import pwm_fine_step_pkg::*;
    logic [5:0] cnt_r;
    logic [7:0] ar_r;
    logic [7:0] aw_r;
    logic [1:0] pin_r;
    logic [1:0] chg2_r;
    logic [1:0] chg3_r;
    // counter mirror; pin changes inside counts 1..62 may only be the pulse end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r <= 6'h00;
            ar_r <= 8'h00;
            aw_r <= 8'h00;
            pin_r <= 2'h0;
            chg2_r <= 2'h0;
            chg3_r <= 2'h0;
        end
        else
        begin
            cnt_r <= cnt_r + 6'h01;
            pin_r <= {pwm_out_ch3, pwm_out_ch2};
            if (s_axi_arvalid && s_axi_arready)
                ar_r <= s_axi_araddr;
            if (s_axi_awvalid && s_axi_awready)
                aw_r <= s_axi_awaddr;
            if (cnt_r == 6'h00)
            begin
                chg2_r <= 2'h0;
                chg3_r <= 2'h0;
            end
            else if (cnt_r != 6'h3f)
            begin
                if (pwm_out_ch2 != pin_r[0] && chg2_r != 2'h3)
                    chg2_r <= chg2_r + 2'h1;
                if (pwm_out_ch3 != pin_r[1] && chg3_r != 2'h3)
                    chg3_r <= chg3_r + 2'h1;
            end
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read answer late");
    a_rsvd_one: assert property (
        s_axi_rvalid && ar_r[7:3] == 5'h00 |-> s_axi_rdata[7] && s_axi_rdata[31:8] == 24'h0)
        else $error("weight top bit not one");
    a_rd_unmapped: assert property (s_axi_rvalid && ar_r[7:2] > 6'h04 |->
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read answer");
    a_wr_unmapped: assert property (s_axi_bvalid && aw_r[7:2] > 6'h04 |->
        s_axi_bresp == RESP_SLVERR) else $error("bad write answer");
    a_ch2_one_end: assert property (chg2_r < 2'h2) else $error("ch2 pin changed twice");
    a_ch3_one_end: assert property (chg3_r < 2'h2) else $error("ch3 pin changed twice");
    a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> s_axi_awready &&
        s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !pwm_out_ch2 && !pwm_out_ch3)
        else $error("not idle after reset");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_widen: cover property (cnt_r == 6'h3f && pwm_out_ch2 != pin_r[0]);
endmodule
bind pwm_fine_step_generator pwm_fine_step_monitor u_mon (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pwm_out_ch2(pwm_out_ch2),
    .pwm_out_ch3(pwm_out_ch3));
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking bench: register access over the bus and cycle-exact pin shape
// assumes the rc filter model and the bound checker are compiled alongside
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pwm_fine_step_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, pin2, pin3, clr;
    logic [7:0] awaddr, araddr, lrate, srate;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, len, sen;
    logic [6:0] lw2, lw3, sw2, sw3;
    logic [9:0] cyc;
    logic [10:0] q2, q3;
    int error_cnt, total_checks, seed;
    pwm_fine_step_generator DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pwm_out_ch2(pin2), .pwm_out_ch3(pin3));
    pwm_rc_filter f2 (.aclk(aclk), .clr(clr), .pin(pin2), .charge(q2));
    pwm_rc_filter f3 (.aclk(aclk), .clr(clr), .pin(pin3), .charge(q3));
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    // widening periods of the sixteen-period sequence
    function automatic logic widen(input logic [3:0] i, input logic [3:0] r);
        return (r[0] && i == 4'h8) || (r[1] && (i == 4'h4 || i == 4'hc)) ||
            (r[2] && i[1:0] == 2'h2) || (r[3] && i[0]);
    endfunction
    // the extra clock sits in the count 63 slot ahead of the next period
    function automatic logic pin_exp(input logic [9:0] t, input logic [6:0] wp,
                                     input logic [3:0] r, input logic en);
        logic act;
        act = (t[5:0] == 6'h3f) ? widen(t[9:6] + 4'h1, r) : (t[5:0] < wp[5:0]);
        return (act && en) ^ wp[6];
    endfunction
    // high time over one full sequence is {weight, rate} when enabled, zero when not, and 1024 minus that when inverted
    function automatic logic [10:0] charge_exp(input logic [6:0] wp, input logic [3:0] r,
                                               input logic en);
        logic [10:0] v;
        v = en ? {1'b0, wp[5:0], r} : 11'h000;
        return wp[6] ? 11'h400 - v : v;
    endfunction
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 50);
        r = bresp;
        bready <= 1'b0;
        if (n >= 50)
        begin
            error_cnt++;
            give_verdict();
        end
    endtask
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready)
                arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 50)
        begin
            error_cnt++;
            give_verdict();
        end
    endtask
    // reference time base, live registers and the per-period shadow copy
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cyc <= 10'h000;
            {lw2, lw3, lrate, len, sw2, sw3, srate, sen} <= '0;
        end
        else
        begin
            cyc <= cyc + 10'h001;
            if (awvalid && awready && wvalid && wready && wstrb[0])
                case (awaddr[7:2])
                    6'h00: lw2 <= wdata[6:0];
                    6'h01: lw3 <= wdata[6:0];
                    6'h02: lrate <= wdata[7:0];
                    6'h03: len <= wdata[1:0];
                    default: ;
                endcase
            if (cyc[5:0] == 6'h3e)
                {sw2, sw3, srate, sen} <= {lw2, lw3, lrate, len};
        end
    end
    // pins checked every cycle while writes land mid-period, ahead of the shadow load
    always @(negedge aclk)
    begin
        if (aresetn)
        begin
            chk1("pin_ch2", pin_exp(cyc, sw2, srate[3:0], sen[0]), pin2);
            chk1("pin_ch3", pin_exp(cyc, sw3, srate[7:4], sen[1]), pin3);
        end
    end
    initial
    begin
        logic [31:0] v2, v3, rt, d;
        logic [1:0] r, en;
        int n;
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        wstrb = 4'h1;
        clr = 1'b0;
        aresetn = 1'b0;
        seed = 90;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (int a = 0; a < 4; a++)
        begin
            axi_read(8'(4 * a), d, r);
            chk32("reset_value", (a < 2) ? 32'h80 : 32'h0, d);
        end
        axi_write(8'h14, $random(seed), r);
        chk32("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        axi_read(8'hfc, d, r);
        chk32("unmapped_rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        // lane 0 strobe low leaves the register alone; the status word ignores writes
        wstrb <= 4'h0;
        axi_write(OFF_PULSE_WEIGHT_CH2, 32'h0000007f, r);
        chk32("masked_bresp", {30'h0, RESP_OKAY}, {30'h0, r});
        wstrb <= 4'h1;
        axi_write(OFF_STATUS, 32'hffffffff, r);
        chk32("status_bresp", {30'h0, RESP_OKAY}, {30'h0, r});
        axi_read(OFF_PULSE_WEIGHT_CH2, d, r);
        chk32("masked_write", 32'h80, d);
        for (int k = 0; k < 12; k++)
        begin
            v2 = $random(seed);
            v3 = $random(seed);
            rt = $random(seed);
            en = 2'($random(seed));
            if (k < 4)
            begin
                rt[7:0] = {4'h1 << k, 4'h1 << k};
                v2[6:0] = k[0] ? 7'h3f : 7'h00;
                en = 2'h3;
            end
            axi_write(OFF_PULSE_WEIGHT_CH2, v2, r);
            axi_write(OFF_PULSE_WEIGHT_CH3, v3, r);
            axi_write(OFF_RATE_MULT_CH3_CH2, {24'h0, rt[7:0]}, r);
            axi_write(OFF_CHANNEL_ENABLE, {30'h0, en}, r);
            chk32("write_bresp", {30'h0, RESP_OKAY}, {30'h0, r});
            axi_read(OFF_PULSE_WEIGHT_CH3, d, r);
            chk32("weight_ch3", {24'h0, 1'b1, v3[6:0]}, d);
            axi_read(OFF_RATE_MULT_CH3_CH2, d, r);
            chk32("rate", {24'h0, rt[7:0]}, d);
            axi_read(OFF_CHANNEL_ENABLE, d, r);
            chk32("enable", {30'h0, en}, d);
            axi_read(OFF_STATUS, d, r);
            chk32("eff", {12'h0, v3[5:0], rt[7:4], v2[5:0], rt[3:0]}, {10'h0, d[31:10]});
            n = 0;
            do
            begin
                @(negedge aclk);
                n++;
            end while (cyc !== 10'h3fe && n < 2100);
            if (n >= 2100)
            begin
                error_cnt++;
                give_verdict();
            end
            clr = 1'b1;
            @(negedge aclk);
            clr = 1'b0;
            repeat (1024) @(posedge aclk);
            @(negedge aclk);
            chk32("charge_ch2", {21'h0, charge_exp(v2[6:0], rt[3:0], en[0])}, {21'h0, q2});
            chk32("charge_ch3", {21'h0, charge_exp(v3[6:0], rt[7:4], en[1])}, {21'h0, q3});
        end
        give_verdict();
    end
endmodule
`default_nettype wire
